/* File: src/slst_pkg.sv */
// Package: constants, types and register map of the serial link self-test block
package slst_pkg;
    // ========================================================
    // Register byte offsets
    localparam logic [7:0] SLST_CTRL_OFS     = 8'h00;
    localparam logic [7:0] SLST_FUNC_CNT_OFS = 8'h04;
    localparam logic [7:0] SLST_TEST_CNT_OFS = 8'h08;
    localparam logic [7:0] SLST_STATUS_OFS   = 8'h0C;
    localparam logic [7:0] SLST_IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] SLST_IRQ_MASK_OFS = 8'h14;
    // ========================================================
    // Field positions
    localparam int SLST_CTRL_PWR_DOWN  = 0;
    localparam int SLST_CTRL_FUNC_CLR  = 1;
    localparam int SLST_CTRL_TEST_CLR  = 2;
    localparam int SLST_STAT_LINK_DET  = 0;
    localparam int SLST_STAT_TEST_MODE = 1;
    localparam int SLST_STAT_PWR_ON    = 2;
    localparam int SLST_STAT_OSC_SEL   = 3;
    localparam int SLST_IRQ_ENTER      = 0;
    localparam int SLST_IRQ_EXIT       = 1;
    localparam int SLST_IRQ_CRC        = 2;
    localparam int SLST_IRQ_W          = 3;
    // ========================================================
    // Reset values, counter limit and bus response codes
    localparam logic [7:0]          SLST_CNT_RST  = 8'h00;
    localparam logic [7:0]          SLST_CNT_MAX  = 8'hFF;
    localparam logic [SLST_IRQ_W-1:0] SLST_MASK_RST = 3'h0;
    localparam logic [1:0]          SLST_RESP_OK  = 2'h0;
    localparam logic [1:0]          SLST_RESP_ERR = 2'h2;
    // ========================================================
    // Timing
    localparam int SLST_CLK_MHZ      = 100;
    localparam int SLST_WAKE_TIME_NS = 1000;
    localparam int SLST_WAKE_CYCLES  = (SLST_WAKE_TIME_NS * SLST_CLK_MHZ + 999) / 1000;
    localparam int SLST_OSC_MHZ      = 33;
    // ========================================================
    // Types
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_WAKE   = 3'b010,
        ST_TEST   = 3'b100
    } slst_state_e;

    typedef struct packed {
        logic [23:0] rgb;
        logic        hs;
        logic        vs;
        logic        de;
    } slst_video_s;

    typedef struct packed {
        logic frame_valid;
        logic crc_err;
        logic test_en;
        logic osc_req;
    } slst_bc_s;
endpackage : slst_pkg

/* File: src/slst_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module slst_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule : slst_sync3

/* File: src/slst_self_test.sv */
// Serializer-side self-test control, pattern substitution and CRC counters
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// RQ1: The far end starts self-test from its test-enable pin or a register bit.
// RQ2: The test runs on pixel clock or the 33 MHz oscillator, chosen when no pixel clock exists.
// RQ3: A back-channel test-enable makes the serializer send the pattern at full rate.
// RQ4: A powered-down serializer wakes before it starts the pattern.
// RQ5: In self-test the video input is not sampled and all zeros go to the scrambler.
// RQ6: The far end compares recovered data with zeros and records mismatches.
// RQ7: With both ends in test and lock held, the far end drives its result pin high.
// RQ8: The far end pulses the result pin low half a pixel period per errored frame. The far-end model holds it low until the next test instead.
// RQ9: On test-enable low the far end latches pass or fail until new test or reset.
// RQ10: When test-enable drops both ends resume normal video.
// RQ11: The test-enable pulse width sets the test duration.
// RQ12: The far end keeps lock valid through the whole test.
// RQ13: Back-channel CRC errors are counted only while link detect is set.
// RQ14: CRC errors go into 8-bit counters cleared on entry to self-test.
// RQ15: From self-test entry the functional counter records every CRC-flagged frame.
// RQ16: The self-test counter counts only in test and holds its value afterwards.
module slst_self_test
    import slst_pkg::*;
#(
    parameter int WAKE_CYCLES = SLST_WAKE_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire slst_video_s video_in,
    input  wire slst_bc_s    bc_in,
    input  wire logic        link_detect,
    input  wire logic        pclk_present,
    output slst_video_s      tx_video_r,
    output logic             self_test_mode_r,
    output logic             osc_sel_r,
    output logic             tx_power_on_r,
    output logic             irq_r,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ========================================================
    // Declarations
    slst_state_e           state_r;
    slst_state_e           state_nxt;
    logic [15:0]           wake_cnt_r;
    logic [7:0]            func_cnt_r;
    logic [7:0]            test_cnt_r;
    logic [2:0]            ctrl_r;
    logic [SLST_IRQ_W-1:0] irq_stat_r;
    logic [SLST_IRQ_W-1:0] irq_mask_r;
    logic                  pclk_ok;
    logic                  enter_test;
    logic                  leave_test;
    logic                  crc_ev;
    logic                  wr_go;
    logic                  rd_go;
    logic                  func_clr;
    logic                  test_clr;
    logic                  ctrl_wr;
    logic                  mask_wr;
    logic [SLST_IRQ_W-1:0] irq_stat_nxt;
    logic [SLST_IRQ_W-1:0] irq_mask_nxt;
    logic                  irq_rd_clr;
    logic [SLST_IRQ_W-1:0] irq_ev;
    logic [7:0]            wr_ofs;
    logic [7:0]            rd_ofs;
    logic                  rd_hit;
    logic                  wr_hit;
    logic [31:0]           rd_val;

    function automatic logic [7:0] cnt_step(input logic [7:0] cnt, input logic clr,
                                            input logic inc);
        logic [7:0] base;
        base = clr ? SLST_CNT_RST : cnt;
        cnt_step = (inc && base != SLST_CNT_MAX) ? base + 8'h01 : base;
    endfunction : cnt_step

    slst_sync3 #(.RST_VAL(1'b0)) slst_sync3_i (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (pclk_present),
        .dout    (pclk_ok)
    );

    // ========================================================
    // Mode sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (bc_in.test_en) begin
                    state_nxt = tx_power_on_r ? ST_TEST : ST_WAKE; // RQ3 RQ4
                end
            end
            ST_WAKE: begin
                if (!bc_in.test_en) begin
                    state_nxt = ST_NORMAL;
                end else if (wake_cnt_r == 16'(WAKE_CYCLES - 1)) begin
                    state_nxt = ST_TEST; // RQ4
                end
            end
            ST_TEST: begin
                if (!bc_in.test_en) begin
                    state_nxt = ST_NORMAL; // RQ10
                end
            end
            default: state_nxt = ST_NORMAL;
        endcase
    end

    assign enter_test = (state_nxt == ST_TEST) && (state_r != ST_TEST);
    assign leave_test = (state_nxt != ST_TEST) && (state_r == ST_TEST);
    assign crc_ev     = link_detect && bc_in.frame_valid && bc_in.crc_err; // RQ13

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r    <= ST_NORMAL;
            wake_cnt_r <= 16'h0000;
        end else begin
            state_r    <= state_nxt;
            wake_cnt_r <= (state_r == ST_WAKE) ? wake_cnt_r + 16'h0001 : 16'h0000;
        end
    end

    // ========================================================
    // Power, clock choice and video path
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_power_on_r    <= 1'b1;
            self_test_mode_r <= 1'b0;
            osc_sel_r        <= 1'b0;
            tx_video_r       <= '0;
        end else begin
            // Wake wins over a software power-down while a test is pending
            tx_power_on_r    <= (state_nxt != ST_NORMAL) || !ctrl_r[SLST_CTRL_PWR_DOWN]; // RQ4
            self_test_mode_r <= (state_nxt == ST_TEST);
            osc_sel_r        <= (state_nxt == ST_TEST) && (bc_in.osc_req || !pclk_ok); // RQ2
            if (state_r == ST_TEST) begin
                tx_video_r <= '0; // RQ5
            end else begin
                tx_video_r <= video_in; // RQ10
            end
        end
    end

    // ========================================================
    // CRC error counters
    assign ctrl_wr  = wr_go && wr_hit && wr_ofs == SLST_CTRL_OFS && s_axi_wstrb[0];
    assign mask_wr  = wr_go && wr_hit && wr_ofs == SLST_IRQ_MASK_OFS && s_axi_wstrb[0];
    assign func_clr = enter_test || (ctrl_wr && s_axi_wdata[SLST_CTRL_FUNC_CLR]);
    assign test_clr = enter_test || (ctrl_wr && s_axi_wdata[SLST_CTRL_TEST_CLR]);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            func_cnt_r <= SLST_CNT_RST;
            test_cnt_r <= SLST_CNT_RST;
        end else begin
            func_cnt_r <= cnt_step(func_cnt_r, func_clr, crc_ev); // RQ14 RQ15
            test_cnt_r <= cnt_step(test_cnt_r, test_clr,
                                   crc_ev && (state_nxt == ST_TEST)); // RQ14 RQ16
        end
    end

    // ========================================================
    // AXI4-Lite slave
    assign wr_go  = s_axi_awready && s_axi_awvalid;
    assign rd_go  = s_axi_arready && s_axi_arvalid;
    assign wr_ofs = s_axi_awaddr[7:0];
    assign rd_ofs = s_axi_araddr[7:0];
    assign wr_hit = (s_axi_awaddr[31:8] == 24'h000000) &&
                    (wr_ofs == SLST_CTRL_OFS || wr_ofs == SLST_IRQ_MASK_OFS);
    assign rd_hit = (s_axi_araddr[31:8] == 24'h000000) && (rd_ofs[1:0] == 2'h0) &&
                    (rd_ofs <= SLST_IRQ_MASK_OFS);
    assign irq_rd_clr = rd_go && rd_hit && rd_ofs == SLST_IRQ_STAT_OFS;
    assign irq_ev = {crc_ev, leave_test, enter_test};
    assign irq_stat_nxt = (irq_rd_clr ? '0 : irq_stat_r) | irq_ev;
    assign irq_mask_nxt = mask_wr ? s_axi_wdata[SLST_IRQ_W-1:0] : irq_mask_r;

    always_comb begin
        rd_val = 32'h00000000;
        if (rd_ofs == SLST_CTRL_OFS) begin
            rd_val[2:0] = ctrl_r;
        end else if (rd_ofs == SLST_FUNC_CNT_OFS) begin
            rd_val[7:0] = func_cnt_r;
        end else if (rd_ofs == SLST_TEST_CNT_OFS) begin
            rd_val[7:0] = test_cnt_r;
        end else if (rd_ofs == SLST_STATUS_OFS) begin
            rd_val[SLST_STAT_LINK_DET]  = link_detect;
            rd_val[SLST_STAT_TEST_MODE] = self_test_mode_r;
            rd_val[SLST_STAT_PWR_ON]    = tx_power_on_r;
            rd_val[SLST_STAT_OSC_SEL]   = osc_sel_r;
        end else if (rd_ofs == SLST_IRQ_STAT_OFS) begin
            rd_val[SLST_IRQ_W-1:0] = irq_stat_r;
        end else if (rd_ofs == SLST_IRQ_MASK_OFS) begin
            rd_val[SLST_IRQ_W-1:0] = irq_mask_r;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= SLST_RESP_OK;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= SLST_RESP_OK;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            // Address and data are taken together in one pulse
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? SLST_RESP_OK : SLST_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_hit ? SLST_RESP_OK : SLST_RESP_ERR;
                s_axi_rdata  <= rd_hit ? rd_val : 32'h00000000;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ========================================================
    // Control, interrupt status and mask
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_r     <= 3'h0;
            irq_mask_r <= SLST_MASK_RST;
            irq_stat_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                // Clear bits act once and are not kept
                ctrl_r <= {1'b0, 1'b0, s_axi_wdata[SLST_CTRL_PWR_DOWN]};
            end
            irq_mask_r <= irq_mask_nxt;
            // New events win over the read clear
            irq_stat_r <= irq_stat_nxt;
            irq_r      <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    // ========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_wake_first;
        (state_r == ST_NORMAL && !tx_power_on_r && bc_in.test_en) |=> (state_r == ST_WAKE);
    endproperty
    a_wake_first: assert property (p_wake_first) else $error("no wake before test"); // RQ4

    property p_test_powered;
        $rose(state_r == ST_TEST) |-> (tx_power_on_r && $past(tx_power_on_r));
    endproperty
    a_test_powered: assert property (p_test_powered) else $error("test while off"); // RQ4

    property p_start_test;
        (state_r == ST_NORMAL && tx_power_on_r && bc_in.test_en) |=> self_test_mode_r;
    endproperty
    a_start_test: assert property (p_start_test) else $error("test not started"); // RQ3

    property p_zero_video;
        (state_r == ST_TEST) |=> (tx_video_r == '0);
    endproperty
    a_zero_video: assert property (p_zero_video) else $error("video not zeroed"); // RQ5

    property p_resume;
        (state_r == ST_TEST && !bc_in.test_en) |=> !self_test_mode_r ##1
            (tx_video_r == $past(video_in));
    endproperty
    a_resume: assert property (p_resume) else $error("normal video not resumed"); // RQ10

    property p_osc;
        (state_nxt == ST_TEST && !pclk_ok) |=> osc_sel_r;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator not chosen"); // RQ2

    property p_no_link;
        (!link_detect && !func_clr) |=> $stable(func_cnt_r);
    endproperty
    a_no_link: assert property (p_no_link) else $error("count without link"); // RQ13

    property p_entry_clear;
        enter_test |=> (test_cnt_r <= 8'h01 && func_cnt_r <= 8'h01);
    endproperty
    a_entry_clear: assert property (p_entry_clear) else $error("no clear on entry"); // RQ14

    property p_func_count;
        (state_r == ST_TEST && crc_ev && !func_clr && func_cnt_r != SLST_CNT_MAX)
            |=> (func_cnt_r == $past(func_cnt_r) + 8'h01);
    endproperty
    a_func_count: assert property (p_func_count) else $error("crc error missed"); // RQ15

    property p_test_hold;
        (state_nxt != ST_TEST && !test_clr) |=> $stable(test_cnt_r);
    endproperty
    a_test_hold: assert property (p_test_hold) else $error("test count moved"); // RQ16

    property p_entry_zero;
        (enter_test && !crc_ev) |=> (test_cnt_r == SLST_CNT_RST && func_cnt_r == SLST_CNT_RST);
    endproperty
    a_entry_zero: assert property (p_entry_zero) else $error("counts not cleared"); // RQ14

    property p_test_count;
        (state_nxt == ST_TEST && crc_ev && !test_clr && test_cnt_r != SLST_CNT_MAX)
            |=> (test_cnt_r == $past(test_cnt_r) + 8'h01);
    endproperty
    a_test_count: assert property (p_test_count) else $error("test count missed"); // RQ16

    property p_video_pass;
        (state_r != ST_TEST) |=> (tx_video_r == $past(video_in));
    endproperty
    a_video_pass: assert property (p_video_pass) else $error("video not passed"); // RQ10

    property p_irq_sticky;
        !irq_rd_clr |=> ((irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r));
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("status bit lost");

    c_wake_path: cover property ((state_r == ST_WAKE) ##1 (state_r == ST_TEST));
    c_direct:    cover property ((state_r == ST_NORMAL && tx_power_on_r) ##1 self_test_mode_r);
    c_crc_test:  cover property ((state_r == ST_TEST) && crc_ev);
    c_irq:       cover property ($rose(irq_r));
    c_osc_req:   cover property (self_test_mode_r && bc_in.osc_req && osc_sel_r);
endmodule : slst_self_test

/* File: tb/slst_far_end.sv */
// Far-end deserializer model: back-channel source and zero-pattern checker
`timescale 1ns/100ps
module slst_far_end
    import slst_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        test_pin,
    input  wire logic        osc_pin,
    input  wire logic        lock_req,
    input  wire logic        frame_go,
    input  wire logic        frame_bad,
    input  wire slst_video_s tx_video,
    input  wire logic        self_test_mode,
    output slst_bc_s         bc_out,
    output logic             link_det,
    output logic             pass_pin,
    output logic [7:0]       err_cnt
);
    logic [1:0] age_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bc_out   <= '0;
            link_det <= 1'b0;
            pass_pin <= 1'b0;
            err_cnt  <= 8'h00;
            age_r    <= 2'h0;
        end else begin
            bc_out.test_en     <= test_pin;
            bc_out.osc_req     <= osc_pin;
            bc_out.frame_valid <= frame_go;
            // Error flag is left dangling between frames
            bc_out.crc_err     <= frame_bad;
            link_det           <= lock_req;
            age_r <= !self_test_mode ? 2'h0 : (age_r == 2'h3 ? age_r : age_r + 2'h1);
            if (test_pin && !bc_out.test_en) begin
                pass_pin <= 1'b1;
                err_cnt  <= 8'h00;
            end else if (self_test_mode && age_r != 2'h0 && tx_video !== '0) begin
                pass_pin <= 1'b0;
                err_cnt  <= err_cnt + 8'h01;
            end
        end
    end
endmodule : slst_far_end

/* File: tb/slst_self_test_bench.sv */
// Bench for the serial link self-test block
`timescale 1ns/100ps
module slst_self_test_bench
    import slst_pkg::*;
;
    localparam int WAKE = 4;
    localparam logic [31:0] PWR = 32'h1 << SLST_STAT_PWR_ON;
    localparam logic [31:0] LNK = 32'h1 << SLST_STAT_LINK_DET;
    localparam logic [31:0] TST = 32'h1 << SLST_STAT_TEST_MODE;
    localparam logic [31:0] OSC = 32'h1 << SLST_STAT_OSC_SEL;
    localparam logic [31:0] I_EN = 32'h1 << SLST_IRQ_ENTER;
    localparam logic [31:0] I_EX = 32'h1 << SLST_IRQ_EXIT;
    localparam logic [31:0] I_CRC = 32'h1 << SLST_IRQ_CRC;
    logic        ref_clk, rst, pclk_present, test_pin, lock_req, frame_go, frame_bad, osc_pin;
    logic        osc_sel_r, tx_power_on_r, irq_r, self_test_mode_r, pass_pin, link_detect;
    slst_video_s video_in, tx_video_r;
    slst_bc_s    bc_in;
    logic [7:0]  err_cnt;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          n_fail, checks_done, n;

    slst_self_test #(.WAKE_CYCLES(WAKE)) slst_self_test_i (.ref_clk, .rst, .video_in, .bc_in,
        .link_detect, .pclk_present, .tx_video_r, .self_test_mode_r, .osc_sel_r, .tx_power_on_r,
        .irq_r, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    slst_far_end slst_far_end_i (.ref_clk, .rst, .test_pin, .osc_pin, .lock_req, .frame_go,
        .frame_bad, .tx_video(tx_video_r), .self_test_mode(self_test_mode_r), .bc_out(bc_in),
        .link_det(link_detect), .pass_pin, .err_cnt);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // =====================================================
    // Checking and bus tasks
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(inout int k);
        @(posedge ref_clk);
        k++;
        if (k > 2000) begin
            chk("wait_bound", 32'h0, 32'h1);
            final_report();
        end
    endtask : tick

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge ref_clk);
        s_axi_awaddr  <= {24'h0, a};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            tick(k);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge ref_clk);
        s_axi_araddr  <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            tick(k);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        chk($sformatf("rdata_%h", a), s_axi_rdata, ev);
    endtask : axr

    task automatic frame(input logic bad);
        @(posedge ref_clk);
        frame_go  <= 1'b1;
        frame_bad <= bad;
        @(posedge ref_clk);
        frame_go  <= 1'b0;
        frame_bad <= ~bad;
        repeat (2) @(posedge ref_clk);
    endtask : frame

    task automatic wait_mode(input logic v);
        n = 0;
        do tick(n); while (self_test_mode_r !== v);
    endtask : wait_mode
    // =====================================================
    // Main sequence
    initial begin
        {rst, pclk_present, test_pin, lock_req, frame_go, frame_bad, osc_pin} = 7'b1100000;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        video_in = 27'h2A5A5A5;
        n_fail = 0;
        checks_done = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        axr(SLST_CTRL_OFS, 32'h0, SLST_RESP_OK);
        axr(SLST_FUNC_CNT_OFS, 32'h0, SLST_RESP_OK);
        axr(SLST_TEST_CNT_OFS, 32'h0, SLST_RESP_OK);
        axr(SLST_STATUS_OFS, PWR, SLST_RESP_OK);
        axr(SLST_IRQ_MASK_OFS, 32'h0, SLST_RESP_OK);
        axr(8'h18, 32'h0, SLST_RESP_ERR);
        axw(SLST_FUNC_CNT_OFS, 32'h1, SLST_RESP_ERR);
        $display("test reset_values done");
        frame(1'b1);
        axr(SLST_FUNC_CNT_OFS, 32'h0, SLST_RESP_OK);
        lock_req <= 1'b1;
        frame(1'b1);
        frame(1'b0);
        frame(1'b1);
        axr(SLST_STATUS_OFS, PWR | LNK, SLST_RESP_OK);
        axr(SLST_FUNC_CNT_OFS, 32'h2, SLST_RESP_OK);
        axr(SLST_TEST_CNT_OFS, 32'h0, SLST_RESP_OK);
        chk("irq_masked", {31'h0, irq_r}, 32'h0);
        axw(SLST_IRQ_MASK_OFS, I_CRC, SLST_RESP_OK);
        repeat (2) @(posedge ref_clk);
        chk("irq_crc", {31'h0, irq_r}, 32'h1);
        axr(SLST_IRQ_STAT_OFS, I_CRC, SLST_RESP_OK);
        repeat (2) @(posedge ref_clk);
        chk("irq_clear", {31'h0, irq_r}, 32'h0);
        axw(SLST_IRQ_MASK_OFS, I_EN | I_EX | I_CRC, SLST_RESP_OK);
        $display("test crc_normal done");
        test_pin <= 1'b1;
        wait_mode(1'b1);
        chk("entry_delay", {31'h0, n <= 3}, 32'h1);
        frame(1'b1);
        frame(1'b1);
        chk("video_zero", {5'h0, tx_video_r}, 32'h0);
        chk("osc_sel", {31'h0, osc_sel_r}, 32'h0);
        osc_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("osc_req", {31'h0, osc_sel_r}, 32'h1);
        axr(SLST_FUNC_CNT_OFS, 32'h2, SLST_RESP_OK);
        axr(SLST_TEST_CNT_OFS, 32'h2, SLST_RESP_OK);
        axr(SLST_STATUS_OFS, PWR | LNK | TST | OSC, SLST_RESP_OK);
        axr(SLST_IRQ_STAT_OFS, I_EN | I_CRC, SLST_RESP_OK);
        osc_pin <= 1'b0;
        test_pin <= 1'b0;
        wait_mode(1'b0);
        repeat (2) @(posedge ref_clk);
        chk("video_back", {5'h0, tx_video_r}, {5'h0, video_in});
        frame(1'b1);
        axr(SLST_FUNC_CNT_OFS, 32'h3, SLST_RESP_OK);
        axr(SLST_TEST_CNT_OFS, 32'h2, SLST_RESP_OK);
        axr(SLST_IRQ_STAT_OFS, I_EX | I_CRC, SLST_RESP_OK);
        $display("test powered_run done");
        for (int i = 0; i < 260; i++) frame(1'b1);
        axr(SLST_FUNC_CNT_OFS, {24'h0, SLST_CNT_MAX}, SLST_RESP_OK);
        $display("test saturation done");
        axw(SLST_CTRL_OFS, 32'h1 << SLST_CTRL_PWR_DOWN, SLST_RESP_OK);
        pclk_present <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("power_down", {31'h0, tx_power_on_r}, 32'h0);
        test_pin <= 1'b1;
        wait_mode(1'b1);
        chk("wake_power", {31'h0, tx_power_on_r}, 32'h1);
        chk("wake_delay", {31'h0, n >= WAKE + 2}, 32'h1);
        chk("osc_sel_nopclk", {31'h0, osc_sel_r}, 32'h1);
        axr(SLST_TEST_CNT_OFS, 32'h0, SLST_RESP_OK);
        frame(1'b1);
        axr(SLST_STATUS_OFS, PWR | LNK | TST | OSC, SLST_RESP_OK);
        test_pin <= 1'b0;
        wait_mode(1'b0);
        axr(SLST_TEST_CNT_OFS, 32'h1, SLST_RESP_OK);
        axw(SLST_CTRL_OFS, 32'h1 << SLST_CTRL_TEST_CLR, SLST_RESP_OK);
        axr(SLST_TEST_CNT_OFS, 32'h0, SLST_RESP_OK);
        chk("far_pass", {31'h0, pass_pin}, 32'h1);
        chk("far_errors", {24'h0, err_cnt}, 32'h0);
        $display("test wake_run done");
        final_report();
    end
endmodule : slst_self_test_bench
